// ==== hdl/spid_core.sv ====
// spid_core.sv: status protection write sequence and id readout of a serial flash
// assumes: pins come straight from the board, CLK_I at least 4x the serial clock
`timescale 1ns/1ps

// Behaviour
// (R1) arm instruction opens protection bits for one following status write only
// (R2) host sends status write right after the arm instruction
// (R3) host frames arm opcode in chip select; device acts at deselect
// (R4) status write updates four protect level bits and lock bit
// (R5) host frames opcode and data; device commits on chip select rise
// (R6) write-protect low and lock set: status write changes no status bit but still ends the arming
// (R7) write-protect low: lock may go 0 to 1, never 1 to 0
// (R8) write-protect high: lock disabled, all bits rewritable
// (R9) permission judged from lock and write-protect just before chip select rises
// (R10) permitted write may set lock and change levels together
// (R11) opcode 9F shifts manufacturer byte, memory type byte, capacity byte
// (R12) chip select rise stops identification output at any bit
// (R13) opcodes 90 and AB start legacy id, followed by 24 address bits
// (R14) legacy id: address 0 gives manufacturer, address 1 device code
// (R15) legacy id alternates both bytes until chip select rises
// (R16) host should prefer legacy id when several flash versions may fit
// (R17) write enable also arms status write; latch cleared when a status write with a full data byte ends
// (R18) arm cancelled if next instruction is not a status write
// (R19) input sampled on clock rise, output changes on clock fall
module spid_core
   import spid_pkg::*;
(
   // clock and reset
   input  wire logic       CLK_I,
   input  wire logic       RST_I,
   // serial pins
   input  wire logic       CS_N_I,
   input  wire logic       SCK_I,
   input  wire logic       SI_I,
   input  wire logic       WP_N_I,
   output logic            SO_O,
   output logic            SO_OE_N_O,
   // status shown to the array logic
   output logic [3:0]      PROTECT_LEVEL_O,
   output logic            PROTECT_LOCK_O,
   output logic            WRITE_LATCH_O,
   output logic            STATUS_ARMED_O
);
`include "spid_regs.svh"

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic cs_n;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic si;
   logic wp_n;

   spid_pin_sync u_cs (
      .clk_i         (CLK_I),
      .rst_i         (RST_I),
      .pin_i         (CS_N_I),
      .reset_level_i (1'b1),
      .level_o       (cs_n),
      .rise_o        (cs_rise),
      .fall_o        ()
   );

   spid_pin_sync u_sck (
      .clk_i         (CLK_I),
      .rst_i         (RST_I),
      .pin_i         (SCK_I),
      .reset_level_i (1'b0),
      .level_o       (),
      .rise_o        (sck_rise),
      .fall_o        (sck_fall)
   );

   spid_pin_sync u_si (
      .clk_i         (CLK_I),
      .rst_i         (RST_I),
      .pin_i         (SI_I),
      .reset_level_i (1'b0),
      .level_o       (si),
      .rise_o        (),
      .fall_o        ()
   );

   spid_pin_sync u_wp (
      .clk_i         (CLK_I),
      .rst_i         (RST_I),
      .pin_i         (WP_N_I),
      .reset_level_i (1'b1),
      .level_o       (wp_n),
      .rise_o        (),
      .fall_o        ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // state
   spid_phase_t phase;
   logic [4:0]  bit_cnt;
   logic [7:0]  shift_in;
   logic [7:0]  opcode;
   logic [7:0]  wr_data;
   logic        wr_data_full;
   logic [23:0] out_shift;
   logic        leg_sel;
   logic [2:0]  leg_bits;
   logic [3:0]  protect_level;
   logic        protect_lock;
   logic        write_latch;
   logic        arm_status;
   logic        arm_pending;
   logic        so;
   logic        so_oe_n;

   // byte complete on this sample edge
   wire         in_active   = ~cs_n & ~cs_rise;
   wire         sample      = in_active & sck_rise;                           // see (R19)
   wire [7:0]   next_byte   = {shift_in[6:0], si};
   wire         byte_done   = sample & (bit_cnt[2:0] == 3'h7);

   // opcode decode
   wire         op_arm      = next_byte == `SPID_OP_STATUS_WRITE_ARM;
   wire         op_write_enable_cmd     = next_byte == `SPID_OP_WRITE_ENABLE_CMD;
   wire         op_status_reg_write     = next_byte == `SPID_OP_STATUS_REG_WRITE;
   wire         op_std_id   = next_byte == `SPID_OP_STD_ID_READ;
   wire         op_leg_id   = (next_byte == `SPID_OP_LEGACY_ID_A) |
                              (next_byte == `SPID_OP_LEGACY_ID_B);        // see (R13)
   // status write allowed only while armed by either enabling instruction
   wire         status_reg_write_armed  = arm_status | write_latch;                   // see (R1) (R17)

   // permission from lock and write-protect just before deselect
   wire         wr_blocked  = ~wp_n & protect_lock;                       // see (R6) (R9)
   wire         wr_commit   = cs_rise & (phase == SPID_WR_DATA) &
                              wr_data_full & status_reg_write_armed;                  // see (R5)
   // lock may be set but not cleared while write-protect is low
   wire         next_lock   = wp_n ? wr_data[`SPID_SR_PROTECT_LOCK]     // see (R8)
                                   : (protect_lock | wr_data[`SPID_SR_PROTECT_LOCK]); // see (R7)
   wire [3:0]   next_level  = wr_data[`SPID_SR_PROTECT_HI:`SPID_SR_PROTECT_LO];

   // id byte streams
   wire [23:0]  std_id_word = {`SPID_ID_MANUFACTURER, `SPID_ID_MEM_TYPE, `SPID_ID_CAPACITY}; // see (R11)
   wire [7:0]   leg_byte0   = `SPID_ID_MANUFACTURER;                      // see (R14)
   wire [7:0]   leg_byte1   = `SPID_ID_CAPACITY;
   // legacy readout flips to the other byte after each eighth output bit
   wire         leg_wrap    = sck_fall & (phase == SPID_LEG_ID) & (leg_bits == 3'h7); // see (R15)
   wire [7:0]   leg_next    = leg_sel ? leg_byte0 : leg_byte1;

   ////////////////////////////////////////////////////////////////////////////
   // input shifting and phase tracking
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         phase        <= SPID_OPCODE;
         bit_cnt      <= 5'h00;
         shift_in     <= 8'h00;
         opcode       <= 8'h00;
         wr_data      <= 8'h00;
         wr_data_full <= 1'b0;
         leg_sel      <= 1'b0;
      end else if (cs_n | cs_rise) begin
         // deselect ends every command
         phase        <= SPID_OPCODE;
         bit_cnt      <= 5'h00;
         wr_data_full <= 1'b0;
      end else if (sample) begin
         shift_in <= next_byte;
         bit_cnt  <= bit_cnt + 5'h01;
         unique case (phase)
            SPID_OPCODE: begin
               if (byte_done) begin
                  opcode  <= next_byte;
                  bit_cnt <= 5'h00;
                  if (op_status_reg_write) begin
                     phase <= SPID_WR_DATA;
                  end else if (op_std_id) begin
                     phase <= SPID_STD_ID;
                  end else if (op_leg_id) begin
                     phase <= SPID_LEG_ADDR;
                  end else begin
                     phase <= SPID_IGNORE;
                  end
               end
            end
            SPID_WR_DATA: begin
               if (byte_done & ~wr_data_full) begin
                  wr_data      <= next_byte;
                  wr_data_full <= 1'b1;
               end
            end
            SPID_LEG_ADDR: begin
               if (bit_cnt == 5'(`SPID_LEGACY_ADDR_BITS - 1)) begin
                  leg_sel <= si;                                          // see (R14)
                  phase   <= SPID_LEG_ID;
                  bit_cnt <= 5'h00;
               end
            end
            SPID_STD_ID,
            SPID_LEG_ID,
            SPID_IGNORE: begin
               bit_cnt <= 5'h00;
            end
         endcase
      end else if (leg_wrap) begin
         leg_sel <= ~leg_sel;                                             // see (R15)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arming and status register
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         arm_status    <= 1'b0;
         arm_pending   <= 1'b0;
         write_latch   <= 1'b0;
         protect_level <= `SPID_PROTECT_RESET;
         protect_lock  <= `SPID_LOCK_RESET;
      end else begin
         // full opcode seen: remember it, act at deselect
         if (byte_done & (phase == SPID_OPCODE)) begin
            arm_pending <= op_arm | op_write_enable_cmd;
            if (~op_status_reg_write) begin
               arm_status <= 1'b0;                                        // see (R18)
            end
         end
         if (cs_rise) begin
            arm_pending <= 1'b0;
            if (arm_pending & (opcode == `SPID_OP_STATUS_WRITE_ARM)) begin
               arm_status <= 1'b1;                                        // see (R1) (R3)
            end else if (arm_pending & (opcode == `SPID_OP_WRITE_ENABLE_CMD)) begin
               write_latch <= 1'b1;                                       // see (R17)
            end else if (phase == SPID_WR_DATA) begin
               // phase, not a stale opcode, marks a status write frame
               // any ended status write clears arm_status; write_latch only once a data byte completed
               arm_status <= 1'b0;
               if (wr_commit) begin
                  write_latch <= 1'b0;                                    // see (R17)
                  if (~wr_blocked) begin
                     protect_level <= next_level;                         // see (R4) (R10)
                     protect_lock  <= next_lock;                          // see (R4) (R10)
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output, changes on the falling clock
   wire out_phase = (phase == SPID_STD_ID) | (phase == SPID_LEG_ID);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         out_shift <= 24'h000000;
         so        <= 1'b0;
         so_oe_n   <= 1'b1;
      end else if (cs_n | cs_rise) begin
         so_oe_n <= 1'b1;                                                 // see (R12)
         so      <= 1'b0;
      end else if (sample & byte_done & (phase == SPID_OPCODE) & op_std_id) begin
         out_shift <= std_id_word;
      end else if (sample & (phase == SPID_LEG_ADDR) &
                   (bit_cnt == 5'(`SPID_LEGACY_ADDR_BITS - 1))) begin
         out_shift <= {si ? leg_byte1 : leg_byte0, 16'h0000};
      end else if (sck_fall & out_phase) begin                            // see (R19)
         so_oe_n <= 1'b0;
         so      <= out_shift[23];
         if (leg_wrap) begin
            // wrap to the other byte after each eight bits
            out_shift <= {leg_next, 16'h0000};                            // see (R15)
         end else begin
            out_shift <= {out_shift[22:0], 1'b0};
         end
      end
   end

   // legacy bit counter on output side
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         leg_bits <= 3'h0;
      end else if (phase != SPID_LEG_ID) begin
         leg_bits <= 3'h0;
      end else if (sck_fall) begin
         leg_bits <= leg_bits + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         SO_O            <= 1'b0;
         SO_OE_N_O       <= 1'b1;
         PROTECT_LEVEL_O <= `SPID_PROTECT_RESET;
         PROTECT_LOCK_O  <= `SPID_LOCK_RESET;
         WRITE_LATCH_O   <= 1'b0;
         STATUS_ARMED_O  <= 1'b0;
      end else begin
         SO_O            <= so;
         SO_OE_N_O       <= so_oe_n;
         PROTECT_LEVEL_O <= protect_level;
         PROTECT_LOCK_O  <= protect_lock;
         WRITE_LATCH_O   <= write_latch;
         STATUS_ARMED_O  <= arm_status;
      end
   end

endmodule : spid_core

// ==== hdl/spid_pin_sync.sv ====
// spid_pin_sync.sv: two-stage synchroniser plus edge finder for serial pins
// assumes: pins are asynchronous to CLK_I; edges are one cycle pulses
`timescale 1ns/1ps
module spid_pin_sync
   import spid_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   input  wire logic reset_level_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic sync;
   logic prev;
   logic seen_a;
   logic seen_b;

   // first stage read only by the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
      end else begin
         meta <= pin_i;
         sync <= meta;
      end
   end

   // idle level shown until both stages hold a real sample, so no false edge follows reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen_a <= 1'b0;
         seen_b <= 1'b0;
         prev   <= 1'b0;
      end else begin
         seen_a <= 1'b1;
         seen_b <= seen_a;
         prev   <= level_o;
      end
   end

   assign level_o = seen_b ? sync : reset_level_i;
   assign rise_o  = seen_b & level_o & ~prev;
   assign fall_o  = seen_b & ~level_o & prev;

endmodule : spid_pin_sync

// ==== pkg/spid_pkg.sv ====
// spid_pkg.sv: types of the spid block
// assumes: spid_regs.svh on the include path
package spid_pkg;
`include "spid_regs.svh"

   typedef enum logic [2:0] {
      SPID_OPCODE,
      SPID_WR_DATA,
      SPID_STD_ID,
      SPID_LEG_ADDR,
      SPID_LEG_ID,
      SPID_IGNORE
   } spid_phase_t;

endpackage : spid_pkg

// ==== pkg/spid_regs.svh ====
// spid_regs.svh: opcodes, status bit positions, id codes and reset values
// assumes: included by the package and the design modules of the spid block
`ifndef SPID_REGS_SVH
`define SPID_REGS_SVH

// opcodes
`define SPID_OP_STATUS_WRITE_ARM 8'h50
`define SPID_OP_STATUS_REG_WRITE 8'h01
`define SPID_OP_WRITE_ENABLE_CMD 8'h06
`define SPID_OP_STD_ID_READ      8'h9F
`define SPID_OP_LEGACY_ID_A      8'h90
`define SPID_OP_LEGACY_ID_B      8'hAB

// status register field positions
`define SPID_SR_WRITE_LATCH      1
`define SPID_SR_PROTECT_LO       2
`define SPID_SR_PROTECT_HI       5
`define SPID_SR_PROTECT_LOCK     7

// status reset value: protect level all set, lock clear
`define SPID_PROTECT_RESET       4'hF
`define SPID_LOCK_RESET          1'b0

// identification codes, values arbitrary
`define SPID_ID_MANUFACTURER     8'hA5
`define SPID_ID_MEM_TYPE         8'h3C
`define SPID_ID_CAPACITY         8'h14

// legacy address length and standard id length, in bits
`define SPID_LEGACY_ADDR_BITS    24
`define SPID_STD_ID_BITS         24

`endif

// ==== test/spid_core_sva.sv ====
// spid_core_sva.sv: port-level checks of the spid core
// assumes: bound to spid_core; host leaves gaps of several clocks around deselect
`timescale 1ns/1ps
module spid_core_sva (
   // clock and reset
   input wire logic       CLK_I,
   input wire logic       RST_I,
   // pins and status
   input wire logic       CS_N_I,
   input wire logic       SCK_I,
   input wire logic       SI_I,
   input wire logic       WP_N_I,
   input wire logic       SO_O,
   input wire logic       SO_OE_N_O,
   input wire logic [3:0] PROTECT_LEVEL_O,
   input wire logic       PROTECT_LOCK_O,
   input wire logic       WRITE_LATCH_O,
   input wire logic       STATUS_ARMED_O
);
   logic       cs_q;
   logic       sck_q;
   logic [3:0] since_rise;
   logic [3:0] since_fall;
   wire  [4:0] status = {PROTECT_LOCK_O, PROTECT_LEVEL_O};
   ////////////////////////////////////////////////////////////////////////////////
   // saturating counts of clocks since the last deselect and the last serial clock fall
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_q       <= 1'b1;
         sck_q      <= 1'b0;
         since_rise <= 4'hF;
         since_fall <= 4'hF;
      end else begin
         cs_q       <= CS_N_I;
         sck_q      <= SCK_I;
         since_rise <= (CS_N_I && !cs_q) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
         since_fall <= (!SCK_I && sck_q) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_reset_idle: assert property ($fell(RST_I) |-> status == 5'h0F && !WRITE_LATCH_O && SO_OE_N_O)
      else $error("outputs not idle after reset");
   a_status_at_deselect: assert property ($changed(status) |-> since_rise <= 4'hA)
      else $error("status changed away from deselect");
   a_status_needs_arm: assert property ($changed(status) |-> $past(STATUS_ARMED_O) || $past(WRITE_LATCH_O))
      else $error("status changed without arming");
   a_write_disarms: assert property ($changed(status) |-> !STATUS_ARMED_O && !WRITE_LATCH_O)
      else $error("arming left after status write");
   a_lock_no_clear: assert property ($fell(PROTECT_LOCK_O) |-> $past(WP_N_I, 8))
      else $error("lock cleared while protected");
   a_locked_frozen: assert property ($past(PROTECT_LOCK_O) && !$past(WP_N_I, 8) && !WP_N_I |-> $stable(status))
      else $error("locked status altered");
   a_out_idle_deselect: assert property (CS_N_I [*8] |-> SO_OE_N_O)
      else $error("output driven while deselected");
   a_so_at_fall: assert property ($changed(SO_O) && !SO_OE_N_O && !CS_N_I && !$past(CS_N_I, 6) |-> since_fall <= 4'h6)
      else $error("output moved away from clock fall");
   c_armed: cover property ($rose(STATUS_ARMED_O));
   c_unlock: cover property ($fell(PROTECT_LOCK_O));
   c_id_out: cover property ($fell(SO_OE_N_O));
endmodule : spid_core_sva

bind spid_core spid_core_sva spid_core_sva_i (.CLK_I(CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .SCK_I(SCK_I),
   .SI_I(SI_I), .WP_N_I(WP_N_I), .SO_O(SO_O), .SO_OE_N_O(SO_OE_N_O), .PROTECT_LEVEL_O(PROTECT_LEVEL_O),
   .PROTECT_LOCK_O(PROTECT_LOCK_O), .WRITE_LATCH_O(WRITE_LATCH_O), .STATUS_ARMED_O(STATUS_ARMED_O));

// ==== test/spid_host_model.sv ====
// spid_host_model.sv: serial host driving select, clock and data in mode 0 or 3
// assumes: clk_i is the core clock; one serial clock lasts 8 core clocks
`timescale 1ns/1ps
module spid_host_model (
   // clock and returned data
   input  wire logic clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_n_i,
   // serial pins
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      si_o   = 1'b1;
   end
   // sends tx[n-1:0] msb first; clock stands at cpol between frames
   // cpol 1: clock idles high (mode 3), idle level set while still deselected
   task automatic xfer(input logic [63:0] tx, input int n, input logic cpol, output logic [63:0] rx);
      rx = '0;
      @(negedge clk_i) sck_o <= cpol;
      repeat (4) @(negedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sck_o <= 1'b0;
         si_o  <= tx[i];
         repeat (5) @(negedge clk_i);
         rx = {rx[62:0], so_oe_n_i ? 1'bx : so_i};
         sck_o <= 1'b1;
         repeat (3) @(negedge clk_i);
      end
      sck_o <= cpol;
      repeat (4) @(negedge clk_i);
      cs_n_o <= 1'b1;
      // released line shows the inverse, never a stale bit
      si_o <= ~tx[0];
      repeat (4) @(negedge clk_i);
   endtask : xfer
endmodule : spid_host_model

// ==== test/testbench.sv ====
// testbench.sv: self-checking bench of the spid core
// assumes: host model drives the serial pins; bench drives write protect and reset
`timescale 1ns/1ps
`include "spid_regs.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   import spid_pkg::*;
   localparam logic [7:0] OP_ARM = `SPID_OP_STATUS_WRITE_ARM;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD = `SPID_OP_WRITE_ENABLE_CMD;
   localparam logic [63:0] STD_RD = {32'h0, `SPID_OP_STD_ID_READ, 24'h0};
   localparam logic [23:0] ID = {`SPID_ID_MANUFACTURER, `SPID_ID_MEM_TYPE, `SPID_ID_CAPACITY};
   logic        clk = 1'b0, rst = 1'b1, wp_n = 1'b1, cpol = 1'b0;
   logic        cs_n, sck, si, so, so_oe_n, lock, latch, armed;
   logic [3:0]  lvl;
   logic [63:0] rx;
   logic [4:0]  e_st = 5'h0F;
   logic [31:0] seed = 32'hEDD8;
   int          fails = 0, n_tests = 0;
   always #20 clk = ~clk;
   spid_core spid_core_i (.CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .WP_N_I(wp_n),
      .SO_O(so), .SO_OE_N_O(so_oe_n), .PROTECT_LEVEL_O(lvl), .PROTECT_LOCK_O(lock), .WRITE_LATCH_O(latch),
      .STATUS_ARMED_O(armed));
   spid_host_model spid_host_model_i (.clk_i(clk), .so_i(so), .so_oe_n_i(so_oe_n), .cs_n_o(cs_n),
      .sck_o(sck), .si_o(si));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // lock at bit 4; refused when unarmed or locked under protect
   function automatic logic [4:0] exp_st(input logic [4:0] cur, input logic ok, input logic wp, input logic [7:0] d);
      return (ok && (wp || !cur[4])) ? {d[7], d[5:2]} : cur;
   endfunction : exp_st
   task automatic frame(input logic [63:0] tx, input int n);
      spid_host_model_i.xfer(tx, n, cpol, rx);
      repeat (12) @(negedge clk);
   endtask : frame
   task automatic sr_write(input logic [7:0] op, input logic wp, input logic [7:0] d);
      wp_n = wp;
      if (op != 8'h00) frame({56'h0, op}, 8);
      if (op == OP_WRITE_ENABLE_CMD) `CHK("latch", 1'b1, latch)
      if (op == OP_ARM) `CHK("armed", 1'b1, armed)
      frame({48'h0, `SPID_OP_STATUS_REG_WRITE, d}, 16);
      e_st = exp_st(e_st, op != 8'h00, wp, d);
      `CHK("status", e_st, {lock, lvl})
      `CHK("arming", 2'b00, {armed, latch})
   endtask : sr_write
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      `CHK("reset", 8'hF1, {lvl, lock, latch, armed, so_oe_n})
      $display("test reset done");
      sr_write(8'h00, 1'b1, 8'hA8);
      sr_write(OP_ARM, 1'b1, 8'hA8);
      sr_write(OP_ARM, 1'b0, 8'h04);
      sr_write(OP_WRITE_ENABLE_CMD, 1'b1, 8'h3C);
      sr_write(OP_ARM, 1'b0, 8'h84);
      sr_write(OP_ARM, 1'b0, 8'h00);
      sr_write(OP_WRITE_ENABLE_CMD, 1'b1, 8'h00);
      frame({56'h0, OP_ARM}, 8);
      frame(STD_RD, 32);
      `CHK("std id", ID, rx[23:0])
      `CHK("armed", 1'b0, armed)
      sr_write(8'h00, 1'b1, 8'hFC);
      $display("test protect done");
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         sr_write(seed[1:0] == 2'h0 ? 8'h00 : (seed[0] ? OP_ARM : OP_WRITE_ENABLE_CMD), seed[8], seed[23:16]);
      end
      $display("test random done");
      for (int k = 0; k < 4; k++) begin
         frame({k[1] ? `SPID_OP_LEGACY_ID_B : `SPID_OP_LEGACY_ID_A, 23'h0, k[0], 32'h0}, 64);
         `CHK("legacy id", k[0] ? {2{ID[7:0], ID[23:16]}} : {2{ID[23:16], ID[7:0]}}, rx[31:0])
      end
      frame(STD_RD >> 12, 20);
      `CHK("so enable", 1'b1, so_oe_n)
      frame(STD_RD, 32);
      `CHK("std id", ID, rx[23:0])
      $display("test id done");
      cpol = 1'b1;
      frame(STD_RD, 32);
      `CHK("std id mode 3", ID, rx[23:0])
      sr_write(OP_ARM, 1'b1, 8'h5C);
      $display("test mode 3 done");
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule : testbench
